// >>> dv/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// SPI host controller model
// ----------------------------------------------------------------
module spi_host_model (
  input  wire logic clock,
  input  wire logic dual_line_0_out,
  input  wire logic dual_line_0_oe,
  input  wire logic dual_line_1_out,
  input  wire logic dual_line_1_oe,
  output logic      chip_select_n,
  output logic      serial_clock,
  output wire logic dual_line_0_in,
  output wire logic dual_line_1_in
);
  // Each clock phase spans 5 system clocks, above the synchroniser minimum
  localparam int PHASE = 5;
  logic host_en0;
  logic host_en1;
  logic host_v0;
  logic host_v1;
  logic float_v;
  logic saw_oe;

  initial begin
    chip_select_n = 1'b1;
    serial_clock = 1'b0;
    {host_en0, host_en1, host_v0, host_v1, float_v, saw_oe} = '0;
  end

  // Released lines toggle so a stale value never reads as valid
  always @(posedge clock) float_v <= ~float_v;
  always @(posedge clock) if (dual_line_0_oe === 1'b1 || dual_line_1_oe === 1'b1) saw_oe <= 1'b1;

  assign dual_line_0_in = dual_line_0_oe ? dual_line_0_out : host_en0 ? host_v0 : float_v;
  assign dual_line_1_in = dual_line_1_oe ? dual_line_1_out : host_en1 ? host_v1 : float_v;

  task automatic tick();
    repeat (PHASE) @(negedge clock);
  endtask

  task automatic send(input logic b0, input logic b1);
    host_v0 = b0;
    host_v1 = b1;
    tick();
    serial_clock = 1'b1;
    tick();
    serial_clock = 1'b0;
  endtask

  // Opcode and payload MSB first; chip select rises after the last clock
  task automatic frame(input logic [7:0] op, input logic [63:0] pay, input int pb,
                       input int rb, input bit dual, output logic [63:0] rd);
    int i;
    rd = '0;
    saw_oe = 1'b0;
    @(negedge clock);
    chip_select_n = 1'b0;
    host_en0 = 1'b1;
    tick();
    for (i = 7; i >= 0; i--) send(op[i], 1'b0);
    host_en1 = dual;
    if (dual) for (i = pb - 2; i >= 0; i -= 2) send(pay[i], pay[i+1]);
    else for (i = pb - 1; i >= 0; i--) send(pay[i], 1'b0);
    host_en0 = 1'b0;
    host_en1 = 1'b0;
    for (i = 0; i < rb; i += (dual ? 2 : 1)) begin
      tick();
      rd = dual ? {rd[61:0], dual_line_1_in, dual_line_0_in} : {rd[62:0], dual_line_1_in};
      serial_clock = 1'b1;
      tick();
      serial_clock = 1'b0;
    end
    tick();
    chip_select_n = 1'b1;
    repeat (8) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// >>> dv/testbench.sv
`include "flash_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flash_cmd_pkg::*;
  localparam logic [7:0]  MFR  = 8'h5a;  // Arbitrary value
  localparam logic [7:0]  DEV  = 8'h10;  // Arbitrary value
  localparam logic [7:0]  TYP  = 8'h30;
  localparam logic [7:0]  CAP  = 8'h11;
  localparam logic [63:0] UNIQ = 64'hfeed_0123_4567_beef;
  localparam int          LIMIT = 40000;
  logic        clock;
  logic        nrst;
  logic        wel_set;
  logic        other_busy;
  protect_t    protect;
  wire logic   cs_n;
  wire logic   sclk;
  wire logic   l0_in;
  wire logic   l1_in;
  wire logic   l0_out;
  wire logic   l0_oe;
  wire logic   l1_out;
  wire logic   l1_oe;
  wire logic   write_enable_latch;
  wire logic   busy;
  wire logic   power_down;
  wire logic   erase_all_strobe;
  logic [63:0] rd;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          strobes = 0;
  int          cycles = 0;

  flash_cmd_core #(.MFR_ID(MFR), .DEVICE_ID(DEV), .MEM_TYPE(TYP), .CAPACITY(CAP),
    .UNIQUE_NUM(UNIQ), .ERASE_CYCLES(600)) u_flash_cmd_core (
    .clock(clock), .nrst(nrst), .chip_select_n(cs_n), .serial_clock(sclk),
    .dual_line_0_in(l0_in), .dual_line_1_in(l1_in), .protect(protect),
    .wel_set(wel_set), .other_busy(other_busy), .dual_line_0_out(l0_out),
    .dual_line_0_oe(l0_oe), .dual_line_1_out(l1_out), .dual_line_1_oe(l1_oe),
    .write_enable_latch(write_enable_latch), .busy(busy), .power_down(power_down),
    .erase_all_strobe(erase_all_strobe));

  spi_host_model u_spi_host_model (
    .clock(clock), .dual_line_0_out(l0_out), .dual_line_0_oe(l0_oe),
    .dual_line_1_out(l1_out), .dual_line_1_oe(l1_oe), .chip_select_n(cs_n),
    .serial_clock(sclk), .dual_line_0_in(l0_in), .dual_line_1_in(l1_in));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) if (erase_all_strobe === 1'b1) strobes++;

  // Hang guard: the whole sequence needs far fewer cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      error_cnt++;
      $display("mismatch timeout expected end seen hang");
      stop_test();
    end
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic xfer(input logic [7:0] op, input logic [63:0] pay, input int pb,
                      input int rb, input bit dl);
    u_spi_host_model.frame(op, pay, pb, rb, dl, rd);
  endtask

  task automatic wel_pulse();
    @(negedge clock) wel_set = 1'b1;
    @(negedge clock) wel_set = 1'b0;
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int a;
    int k;
    logic [7:0] ops [2];
    ops = '{`OP_ERASE_ALL_A, `OP_ERASE_ALL_B};
    {nrst, wel_set, other_busy} = '0;
    protect = '0;
    repeat (5) @(negedge clock);
    nrst = 1'b1;
    repeat (3) @(negedge clock);
    check("power_down", power_down, 0);
    xfer(`OP_STD_ID, 0, 0, 48, 0);
    check("std_id", rd[47:0], {MFR, TYP, CAP, MFR, TYP, CAP});
    check("oe_after_cs", l1_oe, 0);
    for (a = 0; a < 2; a++) begin
      xfer(`OP_MFR_DEV_ID, 64'(a), 24, 32, 0);
      check("mfr_dev", rd[31:0], a ? {DEV, MFR, DEV, MFR} : {MFR, DEV, MFR, DEV});
      xfer(`OP_DUAL_ID, {32'h0, 24'(a), 8'hf0}, 32, 32, 1); // Mode nibble ones
      check("dual_id", rd[31:0], a ? {DEV, MFR, DEV, MFR} : {MFR, DEV, MFR, DEV});
    end
    xfer(`OP_RELEASE_ID, 0, 24, 16, 0);
    check("dev_id", rd[15:0], {DEV, DEV});
    xfer(`OP_UNIQUE_ID, 0, 32, 64, 0);
    check("unique", rd, UNIQ);
    $display("test ids done");
    xfer(`OP_ERASE_ALL_A, 0, 0, 0, 0);
    check("busy_no_wel", busy, 0);
    wel_pulse();
    check("wel", write_enable_latch, 1);
    for (a = 0; a < 2; a++) begin
      protect = a ? 3'b010 : 3'b001;
      xfer(`OP_ERASE_ALL_A, 0, 0, 0, 0);
      check("busy_protected", busy, 0);
    end
    protect = '0;
    xfer(`OP_ERASE_ALL_A, 64'h1, 1, 0, 0);
    check("busy_nine_bits", busy, 0);
    check("strobes_refused", strobes, 0);
    for (k = 0; k < 2; k++) begin
      if (k == 1) wel_pulse(); // Write enable first
      xfer(ops[k], 0, 0, 0, 0);
      check("busy_run", busy, 1);
      check("strobes", strobes, k + 1);
      xfer(`OP_READ_STATUS, 0, 0, 16, 0);
      check("status_busy", rd[15:0], 16'h0303);
      xfer(`OP_RELEASE_ID, 0, 0, 0, 0);
      repeat (100) @(negedge clock);
      check("pd_while_busy", power_down, 0);
      check("busy_kept", busy, 1);
      for (a = 0; a < 1000 && busy !== 1'b0; a++) @(negedge clock);
      check("busy_done", busy, 0);
      check("wel_cleared", write_enable_latch, 0);
    end
    $display("test erase done");
    xfer(`OP_POWER_DOWN, 0, 0, 0, 0);
    repeat (80) @(negedge clock);
    check("pd_entry", power_down, 1);
    xfer(`OP_READ_STATUS, 0, 0, 16, 0);
    check("pd_status_oe", u_spi_host_model.saw_oe, 0);
    xfer(`OP_STD_ID, 0, 0, 8, 0);
    check("pd_id_oe", u_spi_host_model.saw_oe, 0);
    other_busy = 1'b1;
    xfer(`OP_RELEASE_ID, 0, 0, 0, 0);
    repeat (100) @(negedge clock);
    check("pd_other_busy", power_down, 1);
    other_busy = 1'b0;
    xfer(`OP_RELEASE_ID, 0, 0, 0, 0);
    check("pd_in_wait", power_down, 1);
    repeat (70) @(negedge clock); // Chip select held high through the wait
    check("pd_released", power_down, 0);
    xfer(`OP_STD_ID, 0, 0, 8, 0);
    check("id_after_release", rd[7:0], MFR);
    xfer(`OP_POWER_DOWN, 0, 0, 0, 0);
    repeat (80) @(negedge clock);
    xfer(`OP_RELEASE_ID, 0, 24, 8, 0);
    check("pd_dev_id", rd[7:0], DEV);
    repeat (70) @(negedge clock); // Past the plain wait, the longer one still runs
    check("pd_release_wait", power_down, 1);
    repeat (25) @(negedge clock);
    check("pd_release_id", power_down, 0);
    $display("test power done");
    stop_test();
  end
endmodule
`default_nettype wire

// >>> rtl/flash_cmd_core.sv
`include "flash_cmd_map.svh"
`timescale 1ns/1ps
`default_nettype none

module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter logic [7:0]  MFR_ID        = 8'h5a,  // Arbitrary value
  parameter logic [7:0]  DEVICE_ID     = 8'h10,  // Arbitrary value
  parameter logic [7:0]  MEM_TYPE      = 8'h30,  // Arbitrary value
  parameter logic [7:0]  CAPACITY      = 8'h11,  // Arbitrary value
  parameter logic [63:0] UNIQUE_NUM    = 64'h0123_4567_89ab_cdef,  // Arbitrary value
  parameter int unsigned ERASE_CYCLES  = `ERASE_ALL_CYC
) (
  input  wire logic     clock,
  input  wire logic     nrst,
  input  wire logic     chip_select_n,
  input  wire logic     serial_clock,
  input  wire logic     dual_line_0_in,
  input  wire logic     dual_line_1_in,
  input  wire protect_t protect,
  input  wire logic     wel_set,
  input  wire logic     other_busy,
  output logic          dual_line_0_out,
  output logic          dual_line_0_oe,
  output logic          dual_line_1_out,
  output logic          dual_line_1_oe,
  output logic          write_enable_latch,
  output logic          busy,
  output logic          power_down,
  output logic          erase_all_strobe
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic cs_s1, cs_s2, cs_s3, ck_s1, ck_s2, ck_s3;
  logic d0_s1, d0_s2, d1_s1, d1_s2;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
      ck_s1 <= 1'b0;
      ck_s2 <= 1'b0;
      ck_s3 <= 1'b0;
      d0_s1 <= 1'b0;
      d0_s2 <= 1'b0;
      d1_s1 <= 1'b0;
      d1_s2 <= 1'b0;
    end else begin
      cs_s1 <= chip_select_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      ck_s1 <= serial_clock;
      ck_s2 <= ck_s1;
      ck_s3 <= ck_s2;
      d0_s1 <= dual_line_0_in;
      d0_s2 <= d0_s1;
      d1_s1 <= dual_line_1_in;
      d1_s2 <= d1_s1;
    end
  end

  logic ck_rise, ck_fall, cs_rise;
  assign ck_rise = ck_s2 & ~ck_s3;
  assign ck_fall = ~ck_s2 & ck_s3;
  assign cs_rise = cs_s2 & ~cs_s3;

  // ----------------------------------------------------------------
  // Shared state
  // ----------------------------------------------------------------
  cmd_state_t  state_reg;
  logic [7:0]  cmd_reg;
  logic [5:0]  cnt_reg;
  logic [5:0]  need_reg;
  logic [31:0] sh_reg;
  logic        dual_reg, armed_reg, swap_reg, rel_seen_reg, rel_extra_reg;
  logic        erase_busy_reg, pd_reg, wel_reg;
  logic [31:0] erase_cnt_reg;
  logic [15:0] entry_cnt_reg, rel_cnt_reg;
  logic [6:0]  pos_reg;
  logic        busy_any, lockout, no_protect;
  logic [7:0]  opc, status_byte;

  assign busy_any   = erase_busy_reg | other_busy;
  assign lockout    = (entry_cnt_reg != 16'h0000) || (rel_cnt_reg != 16'h0000);
  assign no_protect = ~protect.block_protect_hi & ~protect.block_protect_lo;
  assign opc        = {sh_reg[6:0], d0_s2};

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BUSY_BIT]  = busy_any;
    status_byte[`ST_WEL_BIT]   = wel_reg;
    status_byte[`ST_BP_LO_BIT] = protect.block_protect_lo;
    status_byte[`ST_BP_HI_BIT] = protect.block_protect_hi;
    status_byte[`ST_TB_BIT]    = protect.top_bottom_protect;
  end

  // ----------------------------------------------------------------
  // Command framing
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg     <= ST_OPCODE;
      cmd_reg       <= 8'h00;
      cnt_reg       <= 6'h00;
      need_reg      <= 6'h00;
      sh_reg        <= 32'h0000_0000;
      dual_reg      <= 1'b0;
      armed_reg     <= 1'b0;
      swap_reg      <= 1'b0;
      rel_seen_reg  <= 1'b0;
      rel_extra_reg <= 1'b0;
    end else if (cs_s2) begin
      state_reg     <= ST_OPCODE;
      cnt_reg       <= 6'h00;
      dual_reg      <= 1'b0;
      armed_reg     <= 1'b0;
      rel_seen_reg  <= 1'b0;
      rel_extra_reg <= 1'b0;
    end else if (ck_rise) begin
      if (state_reg != ST_OPCODE) begin
        armed_reg <= 1'b0;
        if (rel_seen_reg)
          rel_extra_reg <= 1'b1;
      end
      case (state_reg)
        ST_OPCODE: begin
          sh_reg  <= {sh_reg[30:0], d0_s2};
          cnt_reg <= cnt_reg + 6'h01;
          if (cnt_reg == `OPCODE_BITS - 6'h01) begin
            cnt_reg   <= 6'h00;
            cmd_reg   <= opc;
            state_reg <= ST_IGNORE;
            if (!lockout && (!pd_reg || opc == `OP_RELEASE_ID)) begin
              case (opc)
                `OP_ERASE_ALL_A, `OP_ERASE_ALL_B, `OP_POWER_DOWN: begin
                  armed_reg <= 1'b1;
                end
                `OP_RELEASE_ID: begin
                  if (!busy_any) begin
                    rel_seen_reg <= 1'b1;
                    need_reg     <= `ADDR_BITS;
                    state_reg    <= ST_COLLECT;
                  end
                end
                `OP_MFR_DEV_ID: begin
                  need_reg  <= `ADDR_BITS;
                  state_reg <= ST_COLLECT;
                end
                `OP_DUAL_ID: begin
                  need_reg  <= `LONG_IN_BITS;
                  dual_reg  <= 1'b1;
                  state_reg <= ST_COLLECT;
                end
                `OP_UNIQUE_ID: begin
                  need_reg  <= `LONG_IN_BITS;
                  state_reg <= ST_COLLECT;
                end
                `OP_STD_ID, `OP_READ_STATUS: begin
                  state_reg <= ST_OUT;
                end
                default: begin
                  state_reg <= ST_IGNORE;
                end
              endcase
            end
          end
        end
        ST_COLLECT: begin
          // Mode bits are taken but unused: the device does not enter continuous mode here
          if (dual_reg) begin
            sh_reg  <= {sh_reg[29:0], d1_s2, d0_s2};
            cnt_reg <= cnt_reg + 6'h02;
            if (cnt_reg + 6'h02 == need_reg) begin
              swap_reg  <= sh_reg[6];
              state_reg <= ST_OUT;
            end
          end else begin
            sh_reg  <= {sh_reg[30:0], d0_s2};
            cnt_reg <= cnt_reg + 6'h01;
            if (cnt_reg + 6'h01 == need_reg) begin
              swap_reg  <= d0_s2;
              state_reg <= ST_OUT;
            end
          end
        end
        ST_OUT, ST_IGNORE: begin
          state_reg <= state_reg;
        end
        default: begin
          state_reg <= ST_IGNORE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Erase-all and power state
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      erase_busy_reg   <= 1'b0;
      erase_cnt_reg    <= 32'h0000_0000;
      erase_all_strobe <= 1'b0;
      pd_reg           <= 1'b0;
      entry_cnt_reg    <= 16'h0000;
      rel_cnt_reg      <= 16'h0000;
    end else begin
      erase_all_strobe <= 1'b0;
      if (erase_busy_reg) begin
        erase_cnt_reg <= erase_cnt_reg - 32'h0000_0001;
        if (erase_cnt_reg == 32'h0000_0001)
          erase_busy_reg <= 1'b0;
      end
      if (entry_cnt_reg != 16'h0000) begin
        entry_cnt_reg <= entry_cnt_reg - 16'h0001;
        if (entry_cnt_reg == 16'h0001)
          pd_reg <= 1'b1;
      end
      if (rel_cnt_reg != 16'h0000) begin
        rel_cnt_reg <= rel_cnt_reg - 16'h0001;
        if (rel_cnt_reg == 16'h0001)
          pd_reg <= 1'b0;
      end
      if (cs_rise) begin
        if (armed_reg && (cmd_reg == `OP_ERASE_ALL_A || cmd_reg == `OP_ERASE_ALL_B)
            && wel_reg && no_protect && !busy_any) begin
          erase_busy_reg   <= 1'b1;
          erase_cnt_reg    <= ERASE_CYCLES;
          erase_all_strobe <= 1'b1;
        end
        if (armed_reg && cmd_reg == `OP_POWER_DOWN)
          entry_cnt_reg <= 16'(`PD_ENTRY_CYC);
        if (rel_seen_reg && pd_reg)
          rel_cnt_reg <= rel_extra_reg ? 16'(`RELEASE_ID_CYC) : 16'(`RELEASE_CYC);
      end
    end
  end

  // Set wins over the completion clear
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst)
      wel_reg <= 1'b0;
    else if (wel_set)
      wel_reg <= 1'b1;
    else if (erase_busy_reg && erase_cnt_reg == 32'h0000_0001)
      wel_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Output shifter
  // ----------------------------------------------------------------
  logic [63:0] pat, pat_sh;
  logic [6:0]  len, pos_next;
  logic [15:0] pair;

  always_comb begin
    pair = swap_reg ? {DEVICE_ID, MFR_ID} : {MFR_ID, DEVICE_ID};
    case (cmd_reg)
      `OP_RELEASE_ID: begin
        pat = {DEVICE_ID, 56'h0};
        len = `LEN_BYTE;
      end
      `OP_MFR_DEV_ID, `OP_DUAL_ID: begin
        pat = {pair, 48'h0};
        len = `LEN_PAIR;
      end
      `OP_UNIQUE_ID: begin
        pat = UNIQUE_NUM;
        len = `LEN_UNIQUE;
      end
      `OP_STD_ID: begin
        pat = {MFR_ID, MEM_TYPE, CAPACITY, 40'h0};
        len = `LEN_TRIPLE;
      end
      default: begin
        pat = {status_byte, 56'h0};
        len = `LEN_BYTE;
      end
    endcase
    pat_sh   = pat << pos_reg;
    pos_next = pos_reg + (dual_reg ? 7'h02 : 7'h01);
    if (pos_next >= len)
      pos_next = 7'h00;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pos_reg         <= 7'h00;
      dual_line_0_out <= 1'b0;
      dual_line_0_oe  <= 1'b0;
      dual_line_1_out <= 1'b0;
      dual_line_1_oe  <= 1'b0;
    end else if (cs_s2) begin
      pos_reg        <= 7'h00;
      dual_line_0_oe <= 1'b0;
      dual_line_1_oe <= 1'b0;
    end else if (ck_fall && state_reg == ST_OUT) begin
      pos_reg         <= pos_next;
      dual_line_1_out <= pat_sh[63];
      dual_line_1_oe  <= 1'b1;
      dual_line_0_out <= pat_sh[62];
      dual_line_0_oe  <= dual_reg;
    end
  end

  assign write_enable_latch = wel_reg;
  assign busy               = erase_busy_reg;
  assign power_down         = pd_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_erase_needs_wel: assert property (@(posedge clock) disable iff (!nrst)
    $rose(erase_busy_reg) |-> $past(wel_reg)) else $error("erase started without latch");
  a_erase_unprot: assert property (@(posedge clock) disable iff (!nrst)
    $rose(erase_busy_reg) |-> $past(no_protect)) else $error("erase started while protected");
  a_erase_frame: assert property (@(posedge clock) disable iff (!nrst)
    $rose(erase_busy_reg) |-> $past(cs_rise) && erase_all_strobe) else $error("erase off frame");
  a_wel_clear_done: assert property (@(posedge clock) disable iff (!nrst)
    $fell(erase_busy_reg) && !$past(wel_set) |-> !wel_reg) else $error("latch kept after erase");
  a_pd_only_release: assert property (@(posedge clock) disable iff (!nrst)
    pd_reg && state_reg == ST_OUT |-> cmd_reg == `OP_RELEASE_ID) else $error("command in power-down");
  a_pd_entry_time: assert property (@(posedge clock) disable iff (!nrst)
    entry_cnt_reg == 16'h0001 |=> pd_reg) else $error("power-down late");
  a_dual_oe_only: assert property (@(posedge clock) disable iff (!nrst)
    dual_line_0_oe |-> dual_line_1_oe && cmd_reg == `OP_DUAL_ID) else $error("line 0 driven");
  a_cs_ends_cmd: assert property (@(posedge clock) disable iff (!nrst)
    cs_s2 |=> state_reg == ST_OPCODE && !dual_line_1_oe) else $error("command outlived frame");
  a_release_busy: assert property (@(posedge clock) disable iff (!nrst)
    $rose(rel_seen_reg) |-> !$past(busy_any)) else $error("release taken while busy");

endmodule
`default_nettype wire

// >>> rtl/flash_cmd_map.svh
`ifndef FLASH_CMD_MAP_SVH
`define FLASH_CMD_MAP_SVH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define OP_ERASE_ALL_A   8'hc7
`define OP_ERASE_ALL_B   8'h60
`define OP_POWER_DOWN    8'hb9
`define OP_RELEASE_ID    8'hab
`define OP_MFR_DEV_ID    8'h90
`define OP_DUAL_ID       8'h92
`define OP_UNIQUE_ID     8'h4b
`define OP_STD_ID        8'h9f
`define OP_READ_STATUS   8'h05
// ----------------------------------------------------------------
// Frame lengths in bits
// ----------------------------------------------------------------
`define OPCODE_BITS      6'h08
`define ADDR_BITS        6'h18
`define LONG_IN_BITS     6'h20
`define LEN_BYTE         7'h08
`define LEN_PAIR         7'h10
`define LEN_TRIPLE       7'h18
`define LEN_UNIQUE       7'h40
// ----------------------------------------------------------------
// Status byte field positions
// ----------------------------------------------------------------
`define ST_BUSY_BIT      0
`define ST_WEL_BIT       1
`define ST_BP_LO_BIT     2
`define ST_BP_HI_BIT     3
`define ST_TB_BIT        5
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    40
`define PD_ENTRY_NS      3000
`define RELEASE_NS       3000
`define RELEASE_ID_NS    3600
`define ERASE_ALL_MS     250
`define PD_ENTRY_CYC     ((`PD_ENTRY_NS / `CLK_PERIOD_NS) > 0 ? (`PD_ENTRY_NS / `CLK_PERIOD_NS) : 1)
`define RELEASE_CYC      ((`RELEASE_NS / `CLK_PERIOD_NS) > 0 ? (`RELEASE_NS / `CLK_PERIOD_NS) : 1)
`define RELEASE_ID_CYC   ((`RELEASE_ID_NS / `CLK_PERIOD_NS) > 0 ? (`RELEASE_ID_NS / `CLK_PERIOD_NS) : 1)
`define ERASE_ALL_CYC    (`ERASE_ALL_MS * 1000000 / `CLK_PERIOD_NS)
`endif

// >>> rtl/flash_cmd_pkg.sv
package flash_cmd_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE  = 3'b000,
    ST_COLLECT = 3'b001,
    ST_OUT     = 3'b010,
    ST_IGNORE  = 3'b011
  } cmd_state_t;

  typedef struct packed {
    logic top_bottom_protect;
    logic block_protect_hi;
    logic block_protect_lo;
  } protect_t;
endpackage
